// ### hw/cfgx_consts.svh
`ifndef CFGX_CONSTS_SVH
`define CFGX_CONSTS_SVH

// access type: all zeros reads, otherwise one write-enable bit per byte
`define CFGX_ACCESS_READ 4'h0
`define CFGX_ACCESS_ALL 4'hF

// completion status of a successful completion, and of a timed-out one
`define CFGX_CPL_STATUS_OK 3'h0

// cycles the user end has to acknowledge, counted from the request rising
`define CFGX_ACK_LATENCY_DFLT 16

// bridge-internal space: dword addresses below this limit never leave it
`define CFGX_INT_LIMIT_DFLT 10'h014
// dword address of the bridge's last internal capability header
`define CFGX_LAST_CAP_ADDR_DFLT 10'h010
// dword address of the first capability held by the user end
`define CFGX_EXT_CAP_PTR_DFLT 10'h014
// next-pointer field inside a capability header
`define CFGX_NXT_PTR_LSB 8
`define CFGX_NXT_PTR_MSB 15

// user-end register window
`define CFGX_CAP_BASE_DFLT 10'h014
`define CFGX_CAP_NREG_DFLT 4

`endif

// ### hw/cfgx_pkg.sv
package cfgx_pkg;

    typedef logic [3:0] cfgx_access_t;

    typedef enum logic [1:0] {
        CFGX_ST_IDLE = 2'b01,
        CFGX_ST_WAIT = 2'b10
    } cfgx_bst_t;

    typedef struct packed {
        cfgx_bst_t st;
        logic ready;
        logic req;
        logic [9:0] addr;
        logic [2:0] pf;
        logic [10:0] vf;
        logic virt;
        cfgx_access_t atype;
        logic [31:0] wdata;
        logic cpl_valid;
        logic cpl_has_data;
        logic [31:0] cpl_data;
        logic [2:0] cpl_status;
        logic cpl_timeout;
    } cfgx_bridge_state_t;

    // byte-lane merge; any pattern of enables, contiguous or not
    function automatic logic [31:0] cfgx_merge_bytes(
        input logic [31:0] old_val,
        input logic [31:0] new_val,
        input cfgx_access_t be
    );
        logic [31:0] r;
        r = old_val;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[8*i +: 8] = new_val[8*i +: 8];
            end
        end
        return r;
    endfunction

endpackage

// ### hw/cfgx_if.sv
`timescale 1ns/1ps
interface cfgx_if (
    input logic clk,
    input logic rst_b
);
    logic cfg_ext_request;
    logic cfg_ext_ack;
    logic [9:0] cfg_ext_dword_addr;
    logic [2:0] cfg_ext_phys_fn;
    logic [10:0] cfg_ext_virt_fn;
    logic cfg_ext_is_virtual;
    logic [31:0] cfg_ext_read_data;
    logic [31:0] cfg_ext_write_data;
    logic [3:0] cfg_ext_access_type;

    modport bridge (
        input clk,
        input rst_b,
        output cfg_ext_request,
        input cfg_ext_ack,
        output cfg_ext_dword_addr,
        output cfg_ext_phys_fn,
        output cfg_ext_virt_fn,
        output cfg_ext_is_virtual,
        input cfg_ext_read_data,
        output cfg_ext_write_data,
        output cfg_ext_access_type
    );

    modport user (
        input clk,
        input rst_b,
        input cfg_ext_request,
        output cfg_ext_ack,
        input cfg_ext_dword_addr,
        input cfg_ext_phys_fn,
        input cfg_ext_virt_fn,
        input cfg_ext_is_virtual,
        output cfg_ext_read_data,
        input cfg_ext_write_data,
        input cfg_ext_access_type
    );
endinterface

// ### hw/cfgx_ack_timer.sv
`timescale 1ns/1ps
`include "cfgx_consts.svh"
module cfgx_ack_timer #(
    parameter int LIMIT = `CFGX_ACK_LATENCY_DFLT,
    parameter int W = $clog2(LIMIT + 2)
) (
    input logic clk,
    input logic rst_b,
    input logic run,
    output logic expired
);
    typedef struct packed {
        logic [W-1:0] cnt;
        logic expired;
    } cfgx_timer_state_t;

    cfgx_timer_state_t q;
    cfgx_timer_state_t d;

    always_comb begin
        d = q;
        if (run) begin
            // saturates: the waiting end leaves its wait once this fires
            if (!q.expired) begin
                d.cnt = q.cnt + W'(1);
            end
            d.expired = q.expired || (q.cnt + W'(1) >= W'(LIMIT));
        end else begin
            d.cnt = '0;
            d.expired = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign expired = q.expired;
endmodule

// ### hw/cfgx_bridge_end.sv
// What this block does
// - forward requests missing internal registers outward
// - user acks only registers it implements
// - acked write completes without data
// - no ack: timeout, zero data and status
// - hold address, functions, data until ack
// - user acks within latency limit cycles
// - request high for access, drops on ack
// - ack lasts exactly one clock cycle
// - drive ten-bit dword address
// - drive three-bit physical function number
// - drive eleven-bit child virtual function number
// - virtual flag high for virtual functions
// - read data valid with the ack
// - write data carried on write bus
// - access type zero reads, bits enable bytes
// - user honours any byte-enable pattern
// - user registers shared across all functions
// - last internal capability points to user
`timescale 1ns/1ps
`include "cfgx_consts.svh"
module cfgx_bridge_end
    import cfgx_pkg::*;
#(
    parameter int ACK_LATENCY_LIMIT = `CFGX_ACK_LATENCY_DFLT,
    parameter logic [9:0] INT_LIMIT = `CFGX_INT_LIMIT_DFLT,
    parameter logic [9:0] LAST_CAP_ADDR = `CFGX_LAST_CAP_ADDR_DFLT,
    parameter logic [9:0] EXT_CAP_PTR = `CFGX_EXT_CAP_PTR_DFLT
) (
    input logic clk,
    input logic rst_b,
    input logic cfg_req_valid,
    output logic cfg_req_ready,
    input logic [9:0] cfg_req_addr,
    input logic [2:0] cfg_req_phys_fn,
    input logic [10:0] cfg_req_virt_fn,
    input logic cfg_req_is_virtual,
    input cfgx_access_t cfg_req_access_type,
    input logic [31:0] cfg_req_write_data,
    output logic cpl_valid,
    output logic cpl_has_data,
    output logic [31:0] cpl_data,
    output logic [2:0] cpl_status,
    output logic cpl_timeout,
    cfgx_if.bridge ext
);
    cfgx_bridge_state_t q;
    cfgx_bridge_state_t d;
    logic expired;
    logic int_hit;
    logic [31:0] int_rdata;
    logic [9:0] nxt_ptr_byte;

    // all-zero access type is the only read code; any other is byte enables
    function automatic logic cfgx_is_read(input cfgx_access_t t);
        return t == `CFGX_ACCESS_READ;
    endfunction

    // ack and read data come from logic on this clock: no synchroniser
    cfgx_ack_timer #(
        .LIMIT(ACK_LATENCY_LIMIT)
    ) u_timer (
        .clk(clk),
        .rst_b(rst_b),
        .run(q.st == CFGX_ST_WAIT),
        .expired(expired)
    );

    assign int_hit = cfg_req_addr < INT_LIMIT;
    // pointer is held as a dword address, the header field wants bytes
    assign nxt_ptr_byte = {EXT_CAP_PTR[7:0], 2'b00};

    // only the link into user space is modelled; other internal words read zero
    always_comb begin
        int_rdata = '0;
        if (cfg_req_addr == LAST_CAP_ADDR) begin
            int_rdata[`CFGX_NXT_PTR_MSB:`CFGX_NXT_PTR_LSB] = nxt_ptr_byte[7:0];
        end
    end

    always_comb begin
        d = q;
        d.cpl_valid = 1'b0;
        d.cpl_timeout = 1'b0;
        unique case (q.st)
            CFGX_ST_IDLE: begin
                d.ready = 1'b1;
                if (q.ready && cfg_req_valid) begin
                    d.ready = 1'b0;
                    if (int_hit) begin
                        d.cpl_valid = 1'b1;
                        d.cpl_has_data = cfgx_is_read(cfg_req_access_type);
                        d.cpl_data = d.cpl_has_data ? int_rdata : '0;
                        d.cpl_status = `CFGX_CPL_STATUS_OK;
                    end else begin
                        d.st = CFGX_ST_WAIT;
                        d.req = 1'b1;
                        // fields load only here, so they hold until the ack
                        d.addr = cfg_req_addr;
                        d.pf = cfg_req_phys_fn;
                        d.vf = cfg_req_virt_fn;
                        d.virt = cfg_req_is_virtual;
                        d.atype = cfg_req_access_type;
                        d.wdata = cfg_req_write_data;
                    end
                end
            end
            CFGX_ST_WAIT: begin
                // an ack in the cycle the timer fires still wins
                if (ext.cfg_ext_ack) begin
                    d.st = CFGX_ST_IDLE;
                    d.req = 1'b0;
                    d.cpl_valid = 1'b1;
                    d.cpl_status = `CFGX_CPL_STATUS_OK;
                    if (cfgx_is_read(q.atype)) begin
                        d.cpl_has_data = 1'b1;
                        d.cpl_data = ext.cfg_ext_read_data;
                    end else begin
                        d.cpl_has_data = 1'b0;
                        d.cpl_data = '0;
                    end
                end else if (expired) begin
                    d.st = CFGX_ST_IDLE;
                    d.req = 1'b0;
                    d.cpl_valid = 1'b1;
                    d.cpl_timeout = 1'b1;
                    d.cpl_has_data = cfgx_is_read(q.atype);
                    d.cpl_data = '0;
                    d.cpl_status = `CFGX_CPL_STATUS_OK;
                end
            end
            default: begin
                d.st = CFGX_ST_IDLE;
                d.req = 1'b0;
                d.ready = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            // one constant per field: no field is written twice in reset
            q.st <= CFGX_ST_IDLE;
            q.ready <= 1'b0;
            q.req <= 1'b0;
            q.addr <= 10'h000;
            q.pf <= 3'h0;
            q.vf <= 11'h000;
            q.virt <= 1'b0;
            q.atype <= `CFGX_ACCESS_READ;
            q.wdata <= 32'h0;
            q.cpl_valid <= 1'b0;
            q.cpl_has_data <= 1'b0;
            q.cpl_data <= 32'h0;
            q.cpl_status <= `CFGX_CPL_STATUS_OK;
            q.cpl_timeout <= 1'b0;
        end else begin
            q <= d;
        end
    end

    assign cfg_req_ready = q.ready;
    assign cpl_valid = q.cpl_valid;
    assign cpl_has_data = q.cpl_has_data;
    assign cpl_data = q.cpl_data;
    assign cpl_status = q.cpl_status;
    assign cpl_timeout = q.cpl_timeout;

    assign ext.cfg_ext_request = q.req;
    assign ext.cfg_ext_dword_addr = q.addr;
    assign ext.cfg_ext_phys_fn = q.pf;
    assign ext.cfg_ext_virt_fn = q.vf;
    assign ext.cfg_ext_is_virtual = q.virt;
    assign ext.cfg_ext_write_data = q.wdata;
    assign ext.cfg_ext_access_type = q.atype;
endmodule

// ### hw/cfgx_user_end.sv
`timescale 1ns/1ps
`include "cfgx_consts.svh"
module cfgx_user_end
    import cfgx_pkg::*;
#(
    parameter logic [9:0] CAP_BASE = `CFGX_CAP_BASE_DFLT,
    parameter int NREG = `CFGX_CAP_NREG_DFLT,
    parameter int IW = (NREG > 1) ? $clog2(NREG) : 1
) (
    input logic clk,
    input logic rst_b,
    output logic [NREG*32-1:0] cap_regs,
    cfgx_if.user ext
);
    typedef struct packed {
        logic ack;
        logic served;
        logic [31:0] rdata;
        logic [NREG-1:0][31:0] regs;
    } cfgx_user_state_t;

    cfgx_user_state_t q;
    cfgx_user_state_t d;
    logic hit;
    logic [9:0] offs;
    logic [IW-1:0] idx;

    // function numbers are ignored: one register set serves every function
    assign offs = ext.cfg_ext_dword_addr - CAP_BASE;
    assign idx = offs[IW-1:0];
    assign hit = ext.cfg_ext_dword_addr >= CAP_BASE && {22'h0, offs} < NREG;

    always_comb begin
        d = q;
        d.ack = 1'b0;
        if (!ext.cfg_ext_request) begin
            d.served = 1'b0;
        end else if (hit && !q.ack && !q.served) begin
            d.ack = 1'b1;
            d.served = 1'b1;
            if (ext.cfg_ext_access_type == `CFGX_ACCESS_READ) begin
                d.rdata = q.regs[idx];
            end else begin
                d.regs[idx] = cfgx_merge_bytes(q.regs[idx], ext.cfg_ext_write_data,
                    ext.cfg_ext_access_type);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign ext.cfg_ext_ack = q.ack;
    assign ext.cfg_ext_read_data = q.rdata;
    assign cap_regs = q.regs;
endmodule

// ### verification/cfgx_properties.sv
`timescale 1ns/1ps
module cfgx_properties #(
    parameter int LIMIT = 16,
    parameter logic [9:0] CAP_BASE = 10'h014,
    parameter int NREG = 4
) (
    input logic clk,
    input logic rst_b,
    input logic cfg_ext_request,
    input logic cfg_ext_ack,
    input logic [9:0] cfg_ext_dword_addr,
    input logic [2:0] cfg_ext_phys_fn,
    input logic [10:0] cfg_ext_virt_fn,
    input logic cfg_ext_is_virtual,
    input logic [31:0] cfg_ext_read_data,
    input logic [31:0] cfg_ext_write_data,
    input logic [3:0] cfg_ext_access_type
);
    logic [7:0] hold_q;
    logic in_win;
    assign in_win = (cfg_ext_dword_addr >= CAP_BASE)
        && (int'(cfg_ext_dword_addr) < int'(CAP_BASE) + NREG);

    // cycles the request has stood so far
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            hold_q <= 8'h00;
        end else begin
            hold_q <= cfg_ext_request ? hold_q + 8'h01 : 8'h00;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence s_ack_then_drop;
        cfg_ext_ack ##1 !cfg_ext_request;
    endsequence

    a_ack_in_time: assert property (
        $rose(cfg_ext_request) && in_win |-> ##1 s_ack_then_drop) else $error("late ack");
    a_ack_drops_req: assert property (
        cfg_ext_ack |=> !cfg_ext_request) else $error("request held past ack");
    a_ack_one_cycle: assert property (
        cfg_ext_ack |=> !cfg_ext_ack) else $error("ack longer than one cycle");
    a_ack_in_req: assert property (
        cfg_ext_ack |-> cfg_ext_request) else $error("ack without request");
    a_no_early_ack: assert property (
        $rose(cfg_ext_request) |-> !cfg_ext_ack) else $error("ack with request rise");
    a_ack_in_window: assert property (
        cfg_ext_ack |-> in_win) else $error("ack for unimplemented register");
    a_fields_held: assert property (
        cfg_ext_request && !cfg_ext_ack |=> $stable({cfg_ext_dword_addr, cfg_ext_phys_fn,
        cfg_ext_virt_fn, cfg_ext_is_virtual, cfg_ext_write_data, cfg_ext_access_type}))
        else $error("fields changed before ack");
    a_timeout_bound: assert property (
        hold_q <= 8'(LIMIT + 1)) else $error("request not timed out");
endmodule

// ### verification/config_space_extension_port_tb_top.sv
`timescale 1ns/1ps
module config_space_extension_port_tb_top;
    import cfgx_pkg::*;
    logic clk, rst_b, valid, virt, ready, cpl_v, has, tmo_o;
    logic [9:0] addr;
    logic [2:0] pf, st;
    logic [10:0] vf;
    cfgx_access_t at;
    logic [31:0] wd, cdata;
    logic [127:0] regs;
    int errors = 0;
    int tests_run = 0;

    cfgx_if cfgx_if_inst(.clk(clk), .rst_b(rst_b));
    // short limit keeps the timeout cases quick
    cfgx_bridge_end #(.ACK_LATENCY_LIMIT(2)) cfgx_bridge_end_inst(.clk(clk), .rst_b(rst_b),
        .cfg_req_valid(valid), .cfg_req_ready(ready), .cfg_req_addr(addr),
        .cfg_req_phys_fn(pf), .cfg_req_virt_fn(vf), .cfg_req_is_virtual(virt),
        .cfg_req_access_type(at), .cfg_req_write_data(wd), .cpl_valid(cpl_v),
        .cpl_has_data(has), .cpl_data(cdata), .cpl_status(st), .cpl_timeout(tmo_o),
        .ext(cfgx_if_inst));
    cfgx_user_end cfgx_user_end_inst(.clk(clk), .rst_b(rst_b), .cap_regs(regs),
        .ext(cfgx_if_inst));
    cfgx_properties #(.LIMIT(2)) cfgx_properties_inst(.clk(clk), .rst_b(rst_b),
        .cfg_ext_request(cfgx_if_inst.cfg_ext_request), .cfg_ext_ack(cfgx_if_inst.cfg_ext_ack),
        .cfg_ext_dword_addr(cfgx_if_inst.cfg_ext_dword_addr),
        .cfg_ext_phys_fn(cfgx_if_inst.cfg_ext_phys_fn),
        .cfg_ext_virt_fn(cfgx_if_inst.cfg_ext_virt_fn),
        .cfg_ext_is_virtual(cfgx_if_inst.cfg_ext_is_virtual),
        .cfg_ext_read_data(cfgx_if_inst.cfg_ext_read_data),
        .cfg_ext_write_data(cfgx_if_inst.cfg_ext_write_data),
        .cfg_ext_access_type(cfgx_if_inst.cfg_ext_access_type));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic close_out;
        if (errors == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // one access from the request side; fn is {phys, virt} function number
    task automatic acc(input logic [9:0] a, input cfgx_access_t t, input logic [31:0] d,
        input logic [13:0] fn, input logic v, input logic ext, input logic tmo,
        input logic [31:0] exp);
        int n;
        logic seen;
        seen = 1'b0;
        n = 0;
        while (ready !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        if (ready !== 1'b1) begin
            errors++;
            close_out();
        end
        valid = 1'b1;
        addr = a;
        at = t;
        wd = d;
        {pf, vf} = fn;
        virt = v;
        @(negedge clk);
        valid = 1'b0;
        n = 0;
        while (cpl_v !== 1'b1 && n < 20) begin
            if (cfgx_if_inst.cfg_ext_request === 1'b1 && !seen) begin
                seen = 1'b1;
                chk({cfgx_if_inst.cfg_ext_dword_addr, cfgx_if_inst.cfg_ext_phys_fn,
                    cfgx_if_inst.cfg_ext_virt_fn, cfgx_if_inst.cfg_ext_is_virtual,
                    cfgx_if_inst.cfg_ext_access_type}, {a, fn, v, t});
                chk(cfgx_if_inst.cfg_ext_write_data, d);
            end
            @(negedge clk);
            n++;
        end
        if (cpl_v !== 1'b1) begin
            errors++;
            close_out();
        end
        chk(cdata, exp);
        chk({has, tmo_o, st}, {t == 4'h0, tmo, 3'h0});
        chk(seen, ext);
        // completion pulses stand one cycle, then the request port reopens
        @(negedge clk);
        chk({cpl_v, tmo_o, ready}, 32'h1);
    endtask

    task automatic sc_internal;
        acc(10'h010, 4'h0, 32'h0, 14'h0, 1'b0, 1'b0, 1'b0, 32'h00005000);
        acc(10'h013, 4'h0, 32'h0, 14'h0, 1'b0, 1'b0, 1'b0, 32'h0);
    endtask

    task automatic sc_bytes;
        acc(10'h014, 4'hF, 32'hA1B2C3D4, 14'h1000, 1'b0, 1'b1, 1'b0, 32'h0);
        chk(regs[31:0], 32'hA1B2C3D4);
        acc(10'h015, 4'h5, 32'h55667788, 14'h3FFF, 1'b1, 1'b1, 1'b0, 32'h0);
        chk(regs[63:32], 32'h00660088);
        acc(10'h015, 4'hC, 32'h11223344, 14'h0400, 1'b1, 1'b1, 1'b0, 32'h0);
        acc(10'h015, 4'h0, 32'h0, 14'h0001, 1'b1, 1'b1, 1'b0, 32'h11220088);
        for (int i = 0; i < 4; i++) begin
            acc(10'h016, 4'(1 << i), 32'hF0E1D2C3, 14'h0, 1'b0, 1'b1, 1'b0, 32'h0);
            chk(regs[95:64], 32'hF0E1D2C3 & ~(32'hFFFFFFFF << (8 * (i + 1))));
        end
    endtask

    task automatic sc_timeout;
        acc(10'h018, 4'h0, 32'h0, 14'h0, 1'b0, 1'b1, 1'b1, 32'h0);
        acc(10'h3FF, 4'hF, 32'h12345678, 14'h2ABC, 1'b1, 1'b1, 1'b1, 32'h0);
        acc(10'h017, 4'h0, 32'h0, 14'h0, 1'b0, 1'b1, 1'b0, 32'h0);
    endtask

    // reset lands while an access waits for an ack that never comes
    task automatic sc_reset;
        chk(ready, 32'h1);
        valid = 1'b1;
        addr = 10'h018;
        at = 4'h0;
        wd = 32'h0;
        {pf, vf} = 14'h0;
        virt = 1'b0;
        @(negedge clk);
        valid = 1'b0;
        chk(cfgx_if_inst.cfg_ext_request, 32'h1);
        rst_b = 1'b0;
        @(negedge clk);
        chk({ready, cpl_v, tmo_o, cfgx_if_inst.cfg_ext_request, cfgx_if_inst.cfg_ext_ack},
            32'h0);
        chk(regs[127:96] | regs[95:64] | regs[63:32] | regs[31:0], 32'h0);
        repeat (3) @(negedge clk);
        rst_b = 1'b1;
        acc(10'h014, 4'h0, 32'h0, 14'h0, 1'b0, 1'b1, 1'b0, 32'h0);
    endtask

    initial begin
        rst_b = 1'b0;
        valid = 1'b0;
        virt = 1'b0;
        addr = 10'h000;
        pf = 3'h0;
        vf = 11'h000;
        at = 4'h0;
        wd = 32'h0;
        repeat (16) @(negedge clk);
        rst_b = 1'b1;
        sc_internal();
        sc_bytes();
        sc_timeout();
        sc_reset();
        close_out();
    end
endmodule
